// ### hdl/ccd_cfg.svh
// Purpose: Register map, field positions, reset values and codes for the codec clock block
// Assumes: APB byte address is four times the register index
// Notes: Definitions only
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

// Register indices and APB byte addresses
`define CCD_IDX_ENA 8'h44
`define CCD_IDX_ENB 8'h45
`define CCD_IDX_OSRC 8'h46
`define CCD_IDX_ODIV 8'h47
`define CCD_IDX_CONV 8'h49
`define CCD_IDX_STAT 8'h4a
`define CCD_ADDR_ENA 12'h110
`define CCD_ADDR_ENB 12'h114
`define CCD_ADDR_OSRC 12'h118
`define CCD_ADDR_ODIV 12'h11c
`define CCD_ADDR_CONV 12'h124
`define CCD_ADDR_STAT 12'h128

// Reset values
`define CCD_RST_ENA 8'h00
`define CCD_RST_ENB 8'h00
`define CCD_RST_OSRC 8'h00
`define CCD_RST_ODIV 8'h01
`define CCD_RST_CONV 8'h00

// Writable masks
`define CCD_MASK_ENA 8'h07
`define CCD_MASK_OSRC 8'h07

// Divider enable register A fields
`define CCD_BIT_NDIV 2
`define CCD_BIT_MSTAGE 1
`define CCD_BIT_MIC 0
// Divider enable register B fields
`define CCD_BIT_ADC 6
`define CCD_BIT_DAC 4
`define CCD_BIT_PBCLK 3
`define CCD_BIT_SBCLK 2
`define CCD_BIT_PFS 1
`define CCD_BIT_SFS 0
// Clock output divider fields
`define CCD_BIT_OEN 7
// Converter clock fields
`define CCD_BIT_SRC_AUTO_OFF 5
`define CCD_BIT_SRC_PICK 4
`define CCD_BIT_EN_AUTO_OFF 3
`define CCD_BIT_MAN_ON 2

// Divide ratios for a code of zero
`define CCD_OUT_MAX 8'h80
`define CCD_M_MAX 8'h40
// Highest legal mic divider code
`define CCD_MIC_CODE_MAX 3'h4
`endif

// ### hdl/ccd_pkg.sv
// Purpose: Types shared by the codec clock block
// Assumes: Nothing beyond the config header
// Notes: Encodings follow the register fields
package ccd_pkg;
    // Clock output source selection
    typedef enum logic [2:0] {
        CCD_SRC_PLL = 3'h0,
        CCD_SRC_PBCLK = 3'h1,
        CCD_SRC_SBCLK = 3'h2,
        CCD_SRC_CTRL = 3'h3,
        CCD_SRC_OSC = 3'h4,
        CCD_SRC_DSP = 3'h5,
        CCD_SRC_RSV6 = 3'h6,
        CCD_SRC_RSV7 = 3'h7
    } ccd_src_t;

    // Converter clock rate selection
    typedef enum logic [1:0] {
        CCD_RATE_6M = 2'h0,
        CCD_RATE_3M = 2'h1,
        CCD_RATE_1M5 = 2'h2,
        CCD_RATE_12M = 2'h3
    } ccd_rate_t;
endpackage

// ### hdl/ccd_clock_ctrl.sv
// Purpose: Codec clock divider enables, clock output divider, converter clock divider
// Assumes: Clock sources arrive as levels synchronous to pclk, slower than pclk/2
// Notes: Divided clocks leave as one-cycle ticks, one per N source rising edges
// Operation
// - Register A bit 2 enables N divider
// - Register A bit 1 enables M divider
// - Register A bit 0 enables mic divider
// - Register A bits 7-3 read zero
// - Register B bit 6 enables ADC divider
// - Register B bit 4 enables DAC divider
// - Register B bit 3 enables primary bitclock
// - Register B bit 2 enables secondary bitclock
// - Register B bit 1 enables primary framesync
// - Register B bit 0 enables secondary framesync
// - Three-bit clock output source select, 6-7 reserved
// - Clock output divider bit 7 enables it
// - Clock output ratio, zero means 128
// - Converter rate code, 12 MHz needs oscillator
// - Bit 5 clear selects source automatically
// - Bit 4 picks manual converter source
// - Bit 3 clear enables converter divider automatically
// - Bit 2 is manual converter enable
// - Manual converter ratio 1, 2, 4, 8
// - M ratio zero means 64, auto ignores
// - Mic ratio codes 0-4 give 1..16
`include "ccd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ccd_clock_ctrl (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock source levels
    input wire logic [5:0] clkout_src_level,
    input wire logic audio_clk_level,
    input wire logic osc_clk_level,
    // Clock detection results
    input wire logic auto_detect_active,
    input wire logic [5:0] auto_m_ratio,
    input wire logic [5:0] m_stage_ratio,
    input wire logic [2:0] mic_clock_ratio,
    input wire logic auto_conv_src_osc,
    input wire logic auto_conv_enable,
    // Divider enables to the clock tree
    output logic n_stage_divider_on,
    output logic m_stage_divider_on,
    output logic mic_clock_divider_on,
    output logic adc_modulator_divider_on,
    output logic dac_modulator_divider_on,
    output logic primary_bitclock_divider_on,
    output logic secondary_bitclock_divider_on,
    output logic primary_framesync_divider_on,
    output logic secondary_framesync_divider_on,
    // Divided clock ticks
    output logic clock_output_tick,
    output logic m_stage_tick,
    output logic mic_clock_tick,
    output logic converter_clock_tick
);
    import ccd_pkg::*;

    localparam int NDIV = 4;

    logic [7:0] divider_enable_a_reg;
    logic [7:0] divider_enable_b_reg;
    logic [7:0] clock_output_source_reg;
    logic [7:0] clock_output_divider_reg;
    logic [7:0] converter_clock_config_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [5:0] src_prev_reg;
    logic audio_prev_reg;
    logic osc_prev_reg;
    logic wr_go;
    logic rd_next;
    logic [7:0] rd_byte;
    logic [5:0] src_rise;
    logic audio_rise;
    logic osc_rise;
    ccd_src_t out_src;
    ccd_rate_t conv_rate;
    logic conv_src_osc;
    logic conv_enable;
    logic conv_rate_bad;
    logic [7:0] stat_byte;
    logic [NDIV-1:0] div_en;
    logic [NDIV-1:0] div_src;
    logic [7:0] div_ratio [NDIV];
    logic [NDIV-1:0] div_tick;

    // Code zero stands for the largest ratio
    function automatic logic [7:0] ratio_or_max(input logic [7:0] code,
                                                input logic [7:0] maxv);
        ratio_or_max = (code == 8'h00) ? maxv : code;
    endfunction

    // Address decode, shared by read and write paths
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
        addr_is = (a == r);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = addr_is(a, `CCD_ADDR_ENA) || addr_is(a, `CCD_ADDR_ENB) ||
                      addr_is(a, `CCD_ADDR_OSRC) || addr_is(a, `CCD_ADDR_ODIV) ||
                      addr_is(a, `CCD_ADDR_CONV) || addr_is(a, `CCD_ADDR_STAT);
    endfunction

    // One wait state: answer in the second access cycle
    assign wr_go = psel && penable && pready_reg && pwrite && addr_mapped(paddr);
    assign rd_next = psel && penable && !pready_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= rd_next;
            pslverr_reg <= rd_next && !addr_mapped(paddr);
            prdata_reg <= (rd_next && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Read mux; unmapped reads return zero with an error
    always_comb begin
        rd_byte = 8'h00;
        if (addr_is(paddr, `CCD_ADDR_ENA)) begin
            rd_byte = divider_enable_a_reg;
        end else if (addr_is(paddr, `CCD_ADDR_ENB)) begin
            rd_byte = divider_enable_b_reg;
        end else if (addr_is(paddr, `CCD_ADDR_OSRC)) begin
            rd_byte = clock_output_source_reg;
        end else if (addr_is(paddr, `CCD_ADDR_ODIV)) begin
            rd_byte = clock_output_divider_reg;
        end else if (addr_is(paddr, `CCD_ADDR_CONV)) begin
            rd_byte = converter_clock_config_reg;
        end else if (addr_is(paddr, `CCD_ADDR_STAT)) begin
            rd_byte = stat_byte;
        end
    end

    // Divider enable A; upper bits are read-only zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_enable_a_reg <= `CCD_RST_ENA;
        end else if (wr_go && addr_is(paddr, `CCD_ADDR_ENA)) begin
            divider_enable_a_reg <= pwdata[7:0] & `CCD_MASK_ENA;
        end
    end

    // Divider enable B; reserved bits stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_enable_b_reg <= `CCD_RST_ENB;
        end else if (wr_go && addr_is(paddr, `CCD_ADDR_ENB)) begin
            divider_enable_b_reg <= pwdata[7:0];
        end
    end

    // Clock output source; upper bits read-only zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_source_reg <= `CCD_RST_OSRC;
        end else if (wr_go && addr_is(paddr, `CCD_ADDR_OSRC)) begin
            clock_output_source_reg <= pwdata[7:0] & `CCD_MASK_OSRC;
        end
    end

    // Clock output enable and ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_divider_reg <= `CCD_RST_ODIV;
        end else if (wr_go && addr_is(paddr, `CCD_ADDR_ODIV)) begin
            clock_output_divider_reg <= pwdata[7:0];
        end
    end

    // Converter clock configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_clock_config_reg <= `CCD_RST_CONV;
        end else if (wr_go && addr_is(paddr, `CCD_ADDR_CONV)) begin
            converter_clock_config_reg <= pwdata[7:0];
        end
    end

    // Previous source levels for rising-edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 6'h00;
            audio_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= clkout_src_level;
            audio_prev_reg <= audio_clk_level;
            osc_prev_reg <= osc_clk_level;
        end
    end

    assign src_rise = clkout_src_level & ~src_prev_reg;
    assign audio_rise = audio_clk_level && !audio_prev_reg;
    assign osc_rise = osc_clk_level && !osc_prev_reg;

    // Converter clock source, enable and rate
    assign out_src = ccd_src_t'(clock_output_source_reg[2:0]);
    assign conv_rate = ccd_rate_t'(converter_clock_config_reg[7:6]);
    assign conv_src_osc = converter_clock_config_reg[`CCD_BIT_SRC_AUTO_OFF] ?
                          converter_clock_config_reg[`CCD_BIT_SRC_PICK] :
                          auto_conv_src_osc;
    assign conv_enable = converter_clock_config_reg[`CCD_BIT_EN_AUTO_OFF] ?
                         converter_clock_config_reg[`CCD_BIT_MAN_ON] :
                         auto_conv_enable;
    // 12 MHz cannot be made from the audio clock, so the divider stays quiet
    assign conv_rate_bad = (conv_rate == CCD_RATE_12M) && !conv_src_osc;
    assign stat_byte = {2'h0, conv_rate_bad, conv_src_osc, div_en};

    // Per-divider enable, source tick and ratio
    always_comb begin
        // Clock output divider; reserved sources give no edges
        div_en[0] = clock_output_divider_reg[`CCD_BIT_OEN];
        div_src[0] = (out_src <= CCD_SRC_DSP) ? src_rise[out_src] : 1'b0;
        div_ratio[0] = ratio_or_max({1'b0, clock_output_divider_reg[6:0]},
                                    `CCD_OUT_MAX);
        // M-stage divider; detection overrides the programmed ratio
        div_en[1] = divider_enable_a_reg[`CCD_BIT_MSTAGE];
        div_src[1] = audio_rise;
        div_ratio[1] = ratio_or_max({2'h0, auto_detect_active ? auto_m_ratio : m_stage_ratio},
                                    `CCD_M_MAX);
        // Mic divider; reserved ratio codes keep it stopped
        div_en[2] = divider_enable_a_reg[`CCD_BIT_MIC] &&
                    (mic_clock_ratio <= `CCD_MIC_CODE_MAX);
        div_src[2] = audio_rise;
        div_ratio[2] = 8'h01 << mic_clock_ratio[2:0];
        // Converter divider
        div_en[3] = conv_enable && !conv_rate_bad;
        div_src[3] = conv_src_osc ? osc_rise : audio_rise;
        if (converter_clock_config_reg[`CCD_BIT_EN_AUTO_OFF]) begin
            div_ratio[3] = 8'h01 << converter_clock_config_reg[1:0];
        end else begin
            unique case (conv_rate)
                CCD_RATE_12M: div_ratio[3] = 8'h01;
                CCD_RATE_6M: div_ratio[3] = 8'h02;
                CCD_RATE_3M: div_ratio[3] = 8'h04;
                CCD_RATE_1M5: div_ratio[3] = 8'h08;
            endcase
        end
    end

    // Counting dividers, all of one shape
    generate
        for (genvar g = 0; g < NDIV; g++) begin : gen_div
            logic [7:0] cnt_reg;
            logic tick_reg;
            // Disable clears phase, so re-enable starts from a full period
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= 8'h00;
                    tick_reg <= 1'b0;
                end else if (!div_en[g]) begin
                    cnt_reg <= 8'h00;
                    tick_reg <= 1'b0;
                end else if (div_src[g]) begin
                    if (cnt_reg >= div_ratio[g] - 8'h01) begin
                        cnt_reg <= 8'h00;
                        tick_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                        tick_reg <= 1'b0;
                    end
                end else begin
                    tick_reg <= 1'b0;
                end
            end
            assign div_tick[g] = tick_reg;
        end
    endgenerate

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign n_stage_divider_on = divider_enable_a_reg[`CCD_BIT_NDIV];
    assign m_stage_divider_on = divider_enable_a_reg[`CCD_BIT_MSTAGE];
    assign mic_clock_divider_on = divider_enable_a_reg[`CCD_BIT_MIC];
    assign adc_modulator_divider_on = divider_enable_b_reg[`CCD_BIT_ADC];
    assign dac_modulator_divider_on = divider_enable_b_reg[`CCD_BIT_DAC];
    assign primary_bitclock_divider_on = divider_enable_b_reg[`CCD_BIT_PBCLK];
    assign secondary_bitclock_divider_on = divider_enable_b_reg[`CCD_BIT_SBCLK];
    assign primary_framesync_divider_on = divider_enable_b_reg[`CCD_BIT_PFS];
    assign secondary_framesync_divider_on = divider_enable_b_reg[`CCD_BIT_SFS];
    assign clock_output_tick = div_tick[0];
    assign m_stage_tick = div_tick[1];
    assign mic_clock_tick = div_tick[2];
    assign converter_clock_tick = div_tick[3];

    // Checks on the design's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    sequence s_write_a;
        wr_go && addr_is(paddr, `CCD_ADDR_ENA);
    endsequence

    a_apb_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("APB answer not after one wait state");
    a_res_bits_zero: assert property (divider_enable_a_reg[7:3] == 5'h00)
        else $error("Reserved enable bits not zero");
    a_n_enable_write: assert property (s_write_a |=> n_stage_divider_on == $past(pwdata[2]))
        else $error("N divider enable not written");
    a_m_enable_write: assert property (s_write_a |=> m_stage_divider_on == $past(pwdata[1]))
        else $error("M divider enable not written");
    a_mic_enable_write: assert property (s_write_a |=> mic_clock_divider_on == $past(pwdata[0]))
        else $error("Mic divider enable not written");
    a_enb_write_bits: assert property (wr_go && addr_is(paddr, `CCD_ADDR_ENB) |=>
        {adc_modulator_divider_on, dac_modulator_divider_on, primary_bitclock_divider_on,
         secondary_bitclock_divider_on, primary_framesync_divider_on,
         secondary_framesync_divider_on} == {$past(pwdata[6]), $past(pwdata[4]),
         $past(pwdata[3:0])})
        else $error("Enable register B bits not written");
    a_out_rsv_src: assert property (out_src > CCD_SRC_DSP |=> !clock_output_tick)
        else $error("Reserved source produced ticks");
    a_out_off_quiet: assert property (!clock_output_divider_reg[`CCD_BIT_OEN] |=>
        !clock_output_tick && gen_div[0].cnt_reg == 8'h00)
        else $error("Disabled clock output divider active");
    a_out_div_one: assert property (div_en[0] && clock_output_divider_reg[6:0] == 7'h01 &&
        div_src[0] |=> clock_output_tick)
        else $error("Ratio one does not pass every edge");
    a_conv_rate_bad: assert property (conv_rate == CCD_RATE_12M && !conv_src_osc |=>
        !converter_clock_tick)
        else $error("12 MHz accepted without oscillator");
    a_conv_manual_off: assert property (converter_clock_config_reg[3:2] == 2'h2 |=>
        !converter_clock_tick)
        else $error("Manual disable ignored");
    a_mic_rsv_ratio: assert property (mic_clock_ratio > `CCD_MIC_CODE_MAX |=>
        !mic_clock_tick)
        else $error("Reserved mic ratio produced ticks");
    a_m_ratio_max: assert property (div_en[1] && !auto_detect_active &&
        m_stage_ratio == 6'h00 |-> div_ratio[1] == 8'h40)
        else $error("M ratio zero not 64");
endmodule

`default_nettype wire

// ### verification/codec_clock_divider_enables_tb.sv
// Purpose: Self-checking bench for the codec clock divider enable block
// Assumes: Divider source levels are held two pclk cycles high and two low
// Notes: M and mic dividers are fed from the audio clock level
`include "ccd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module codec_clock_divider_enables_tb;
    import ccd_pkg::*;

    // Compare helper, counts every comparison
    `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); miscompares++; end end

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] clkout_src_level = 6'h00;
    logic audio_clk_level = 1'b0;
    logic osc_clk_level = 1'b0;
    logic auto_detect_active = 1'b0;
    logic [5:0] auto_m_ratio = 6'h01;
    logic [5:0] m_stage_ratio = 6'h01;
    logic [2:0] mic_clock_ratio = 3'h0;
    logic auto_conv_src_osc = 1'b0;
    logic auto_conv_enable = 1'b0;
    logic n_on, m_on, mic_on, adc_on, dac_on, pb_on, sb_on, pf_on, sf_on;
    // Net, as four separate output ports drive its bits
    wire [3:0] tick;
    int tick_cnt[4];
    int miscompares = 0;
    int check_count = 0;

    ccd_clock_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clkout_src_level(clkout_src_level),
        .audio_clk_level(audio_clk_level), .osc_clk_level(osc_clk_level),
        .auto_detect_active(auto_detect_active), .auto_m_ratio(auto_m_ratio),
        .m_stage_ratio(m_stage_ratio), .mic_clock_ratio(mic_clock_ratio),
        .auto_conv_src_osc(auto_conv_src_osc), .auto_conv_enable(auto_conv_enable),
        .n_stage_divider_on(n_on), .m_stage_divider_on(m_on),
        .mic_clock_divider_on(mic_on), .adc_modulator_divider_on(adc_on),
        .dac_modulator_divider_on(dac_on), .primary_bitclock_divider_on(pb_on),
        .secondary_bitclock_divider_on(sb_on), .primary_framesync_divider_on(pf_on),
        .secondary_framesync_divider_on(sf_on), .clock_output_tick(tick[0]),
        .m_stage_tick(tick[1]), .mic_clock_tick(tick[2]),
        .converter_clock_tick(tick[3])
    );

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // One APB transfer; request held until pready is seen high
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("[FAIL] pready expected 1 seen timeout");
            miscompares++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, a, d, rd, err);
        // Register lands at the completing edge; let it settle before checks
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, a, 8'h00, rd, err);
        `CHK("read data", {24'h0, e}, rd)
    endtask

    // Source 0-5 clock output inputs, 6 audio, 7 oscillator
    task automatic set_src(input int which, input logic v);
        if (which < 6) clkout_src_level[which] <= v;
        else if (which == 6) audio_clk_level <= v;
        else osc_clk_level <= v;
    endtask

    // Toggle a source for a number of rising edges and count ticks per output
    task automatic count_case(input int which, input int edges, input int idx, input int e);
        for (int k = 0; k < 4; k++) tick_cnt[k] = 0;
        for (int i = 0; i < edges * 4 + 6; i++) begin
            @(posedge pclk);
            // Unknown ticks are counted too, so they cannot hide
            for (int k = 0; k < 4; k++) tick_cnt[k] += (tick[k] !== 1'b0) ? 1 : 0;
            set_src(which, (i % 4 < 2) && (i < edges * 4));
        end
        `CHK("tick count", e, tick_cnt[idx])
    endtask

    task automatic t_reset_values;
        rd_chk(`CCD_ADDR_ENA, `CCD_RST_ENA);
        rd_chk(`CCD_ADDR_ENB, `CCD_RST_ENB);
        rd_chk(`CCD_ADDR_OSRC, `CCD_RST_OSRC);
        rd_chk(`CCD_ADDR_ODIV, `CCD_RST_ODIV);
        rd_chk(`CCD_ADDR_CONV, `CCD_RST_CONV);
        `CHK("enables after reset", 9'h000, {n_on, m_on, mic_on, adc_on, dac_on, pb_on, sb_on, pf_on, sf_on})
    endtask

    task automatic t_enable_bits;
        wr(`CCD_ADDR_ENA, 8'hff);
        rd_chk(`CCD_ADDR_ENA, 8'h07);
        `CHK("register a enables", 3'h7, {n_on, m_on, mic_on})
        // Walking one shows each bit drives only its own enable
        for (int i = 0; i < 3; i++) begin
            wr(`CCD_ADDR_ENA, 8'h01 << i);
            `CHK("register a walk", 3'h1 << i, {n_on, m_on, mic_on})
        end
        for (int i = 0; i < 8; i++) begin
            wr(`CCD_ADDR_ENB, 8'h01 << i);
            rd_chk(`CCD_ADDR_ENB, 8'h01 << i);
            `CHK("register b walk", (8'h01 << i) & 8'h5f, {1'b0, adc_on, 1'b0, dac_on, pb_on, sb_on, pf_on, sf_on})
        end
    endtask

    task automatic t_access_map;
        logic [31:0] rd;
        logic err;
        wr(`CCD_ADDR_OSRC, 8'hff);
        rd_chk(`CCD_ADDR_OSRC, 8'h07);
        apb_xfer(1'b0, 12'h200, 8'h00, rd, err);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    task automatic t_clock_output;
        // Every legal source code routes its own input
        for (int s = 0; s < 6; s++) begin
            wr(`CCD_ADDR_OSRC, s[7:0]);
            wr(`CCD_ADDR_ODIV, 8'h81);
            count_case(s, 2, 0, 2);
        end
        wr(`CCD_ADDR_OSRC, {5'h0, CCD_SRC_OSC});
        wr(`CCD_ADDR_ODIV, 8'h83);
        count_case(4, 6, 0, 2);
        count_case(1, 6, 0, 0);
        wr(`CCD_ADDR_ODIV, 8'h03);
        count_case(4, 6, 0, 0);
        wr(`CCD_ADDR_ODIV, 8'h80);
        count_case(4, 128, 0, 1);
        wr(`CCD_ADDR_ODIV, 8'hff);
        count_case(4, 127, 0, 1);
    endtask

    task automatic t_m_mic;
        wr(`CCD_ADDR_ENA, 8'h03);
        m_stage_ratio <= 6'h00;
        mic_clock_ratio <= 3'h4;
        count_case(6, 64, 1, 1);
        `CHK("mic ticks at ratio 16", 4, tick_cnt[2])
        auto_detect_active <= 1'b1;
        auto_m_ratio <= 6'h02;
        mic_clock_ratio <= 3'h5;
        count_case(6, 4, 1, 2);
        `CHK("mic reserved code", 0, tick_cnt[2])
        wr(`CCD_ADDR_ENA, 8'h00);
        count_case(6, 4, 1, 0);
    endtask

    task automatic t_converter;
        wr(`CCD_ADDR_CONV, 8'h3f);
        count_case(7, 16, 3, 2);
        wr(`CCD_ADDR_CONV, 8'h3d);
        count_case(7, 4, 3, 2);
        wr(`CCD_ADDR_CONV, 8'h2d);
        count_case(7, 4, 3, 0);
        count_case(6, 4, 3, 2);
        wr(`CCD_ADDR_CONV, 8'h29);
        count_case(6, 4, 3, 0);
        auto_conv_src_osc <= 1'b1;
        auto_conv_enable <= 1'b1;
        wr(`CCD_ADDR_CONV, 8'hc0);
        count_case(7, 4, 3, 4);
        wr(`CCD_ADDR_CONV, 8'h00);
        count_case(7, 4, 3, 2);
        auto_conv_enable <= 1'b0;
        count_case(7, 4, 3, 0);
        auto_conv_enable <= 1'b1;
        auto_conv_src_osc <= 1'b0;
        wr(`CCD_ADDR_CONV, 8'hc0);
        count_case(6, 4, 3, 0);
        // Status: rate invalid, audio source, only clock output divider running
        rd_chk(`CCD_ADDR_STAT, 8'h21);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_enable_bits();
        t_access_map();
        t_clock_output();
        t_m_mic();
        t_converter();
        final_report();
    end

    // Watchdog, well past the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end
endmodule

`default_nettype wire
